// file: hw/anreg_pkg.sv
package anreg_pkg;
	localparam int          REG_W        = 16;
	localparam int          APB_AW       = 12;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0]  IDX_ADV      = 8'h04;
	localparam logic [7:0]  IDX_PARTNER  = 8'h05;
	localparam logic [11:0] ADDR_ADV     = {2'h0, IDX_ADV, 2'h0};
	localparam logic [11:0] ADDR_PARTNER = {2'h0, IDX_PARTNER, 2'h0};
	localparam logic [15:0] ADV_RESET    = 16'h01E1;
	localparam logic [15:0] PARTNER_RESET = 16'h0000;
	localparam int          TECH_HI      = 12;
	localparam int          TECH_LO      = 5;
	localparam int          WR_HI        = 8;
	localparam int          WR_LO        = 5;
	localparam int          SEL_HI       = 4;
	localparam int          SEL_LO       = 0;
	localparam logic [4:0]  SELECTOR_8023 = 5'h01;
	localparam logic [3:0]  WR_RESET     = 4'hF;
endpackage : anreg_pkg

// file: hw/anreg_hold_if.sv
`timescale 1ns/1ns
interface anreg_hold_if #(parameter int W = 16);
	logic         load;
	logic [W-1:0] d;
	logic [W-1:0] q;
	modport owner (input load, input d, output q);
	modport user  (output load, output d, input q);
endinterface : anreg_hold_if

// file: hw/anreg_hold_reg.sv
`timescale 1ns/1ns
module anreg_hold_reg #(
	parameter int           W     = 16,
	parameter logic [W-1:0] RESET = '0
) (
	// clock, reset and enable
	input wire logic     clk,
	input wire logic     rstn,
	input wire logic     ce,
	// held word
	anreg_hold_if.owner  hold
);
	logic [W-1:0] word_q;
	logic [W-1:0] word_d;

	if (W < 1 || W > 32)
	begin : gBadWidth
		$error("anreg_hold_reg: width must be 1 to 32");
	end

	always_comb
	begin
		word_d = word_q;
		if (hold.load)
			word_d = hold.d;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			word_q <= RESET;
		else if (ce)
			word_q <= word_d;
	end

	assign hold.q = word_q;
endmodule : anreg_hold_reg

// file: hw/anreg_ability_regs.sv
`timescale 1ns/1ns
module anreg_ability_regs
	import anreg_pkg::*;
(
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// negotiation engine, same clock
	input  wire logic              anRestart,
	input  wire logic              partnerPageValid,
	input  wire logic [REG_W-1:0]  partnerPageWord,
	output logic [REG_W-1:0]       advertWord
);
	localparam int PAD_W = 32 - REG_W;

	logic [3:0]       ability_q;
	logic [3:0]       ability_d;
	// named views of the writable ability bits
	logic             adv100txFull;
	logic             adv100txHalf;
	logic             adv10tFull;
	logic             adv10tHalf;
	logic [REG_W-1:0] readWord;
	logic [31:0]      prdata_q;
	logic [31:0]      prdata_d;
	logic             pready_q;
	logic             pready_d;
	logic             pslverr_q;
	logic             pslverr_d;
	logic [REG_W-1:0] advReadWord;
	logic             accessFirst;
	logic             accessDone;
	logic             hitAdv;
	logic             hitPartner;

	// elaboration checks: the package layout must fit the fixed register shape
	if (REG_W < 1 || REG_W > 31)
	begin : gBadRegWidth
		$error("anreg_ability_regs: register width must be 1 to 31");
	end

	if (WR_HI - WR_LO + 1 != $bits(ability_q) || $bits(WR_RESET) != $bits(ability_q))
	begin : gBadWritableWidth
		$error("anreg_ability_regs: writable field must match the ability bits");
	end

	if (WR_HI > TECH_HI || WR_LO < TECH_LO)
	begin : gBadWritablePlace
		$error("anreg_ability_regs: writable bits must sit inside the technology field");
	end

	if (TECH_HI >= REG_W)
	begin : gBadTechPlace
		$error("anreg_ability_regs: technology field must fit the register");
	end

	if (SEL_HI - SEL_LO + 1 != $bits(SELECTOR_8023) || SEL_HI >= TECH_LO)
	begin : gBadSelector
		$error("anreg_ability_regs: selector must be five bits below the technology field");
	end

	if (ADV_RESET[WR_HI:WR_LO] != WR_RESET || ADV_RESET[SEL_HI:SEL_LO] != SELECTOR_8023)
	begin : gBadResetValue
		$error("anreg_ability_regs: advertisement reset value disagrees with its fields");
	end

	if (APB_AW != $bits(ADDR_ADV) || ADDR_ADV == ADDR_PARTNER)
	begin : gBadAddressMap
		$error("anreg_ability_regs: address map does not fit the bus");
	end

	if (ADDR_ADV[1:0] != 2'h0 || ADDR_PARTNER[1:0] != 2'h0)
	begin : gBadAlignment
		$error("anreg_ability_regs: register addresses must be word aligned");
	end

	anreg_hold_if #(.W(REG_W)) partnerIf ();
	anreg_hold_if #(.W(REG_W)) advertIf ();

	always_comb
	begin
		{adv100txFull, adv100txHalf, adv10tFull, adv10tHalf} = ability_q;
	end

	// selector hard-wired
	// reserved, remote fault and next page bits are not stored and read as zero
	always_comb
	begin
		advReadWord                 = '0;
		advReadWord[WR_HI:WR_LO]    = {adv100txFull, adv100txHalf, adv10tFull, adv10tHalf};
		advReadWord[SEL_HI:SEL_LO]  = SELECTOR_8023;
	end

	// the whole address is compared, so an unaligned access misses and errs
	// advertisement and partner address decode
	assign hitAdv      = (paddr == ADDR_ADV);
	assign hitPartner  = (paddr == ADDR_PARTNER);
	// one wait state so that every answer comes from a flop
	assign accessFirst = psel && penable && !pready_q;
	assign accessDone  = psel && penable && pready_q;

	always_comb
	begin
		ability_d = ability_q;
		if (accessDone && pwrite && hitAdv)
			ability_d = pwdata[WR_HI:WR_LO];
	end

	// partner word is read-only; unmapped space reads as zero
	always_comb
	begin
		readWord = '0;
		if (hitAdv)
			readWord = advReadWord;
		else if (hitPartner)
			readWord = partnerIf.q;
	end

	always_comb
	begin
		pready_d  = 1'b0;
		prdata_d  = '0;
		pslverr_d = 1'b0;
		if (accessFirst)
		begin
			pready_d  = 1'b1;
			pslverr_d = !(hitAdv || hitPartner);
			if (!pwrite)
				prdata_d = {{PAD_W{1'b0}}, readWord};
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ability_q <= WR_RESET;
		else if (ce)
			ability_q <= ability_d;
	end

	// bus answers are registered so that every output comes from a flop
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign partnerIf.load = partnerPageValid;
	assign partnerIf.d    = partnerPageWord;

	anreg_hold_reg #(.W(REG_W), .RESET(PARTNER_RESET)) partnerHold (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.hold (partnerIf.owner)
	);

	// a write in the same cycle as a restart waits for the next restart
	// advertised word moves only on restart or reset
	// cleared bits drop out at restart
	assign advertIf.load = anRestart;
	assign advertIf.d    = advReadWord;

	anreg_hold_reg #(.W(REG_W), .RESET(ADV_RESET)) advertHold (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.hold (advertIf.owner)
	);

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign advertWord = advertIf.q;
endmodule : anreg_ability_regs

// file: tb/anreg_asserts.sv
`timescale 1ns/1ns
module anreg_asserts
	import anreg_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// negotiation
	input wire logic        anRestart,
	input wire logic [15:0] advertWord
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_sel_fixed: assert property (advertWord[4:0] == SELECTOR_8023) else $error("sel");
	a_adv_hold: assert property (!anRestart |=> $stable(advertWord)) else $error("hold");
	a_rsvd_zero: assert property (advertWord[15:9] == 7'h00) else $error("rsvd");
	a_rdy_wait: assert property (psel && !penable |=> !pready) else $error("wait");
	a_rdy_once: assert property (pready |-> $past(psel && penable) ##1 !pready) else $error("rdy");
	a_err_map: assert property (pready |-> pslverr == !(paddr == ADDR_ADV || paddr == ADDR_PARTNER))
		else $error("err");
	a_rd_upper: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper");
	a_rd_sel: assert property (pready && !pwrite && paddr == ADDR_ADV |-> prdata[4:0] == SELECTOR_8023)
		else $error("rdsel");
endmodule : anreg_asserts
bind anreg_ability_regs anreg_asserts anreg_asserts_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .anRestart, .advertWord);

// file: tb/anreg_partner.sv
`timescale 1ns/1ns
module anreg_partner (
	// clock
	input wire logic        clk,
	// page request from the bench
	input wire logic        go,
	input wire logic [15:0] w,
	// page toward the device
	output logic            vld = 1'b0,
	output logic [15:0]     wd = 16'h5A5A
);
	always @(posedge clk)
	begin
		vld <= go;
		wd <= go ? w : ~wd;
	end
endmodule : anreg_partner

// file: tb/anreg_ability_regs_test.sv
`timescale 1ns/1ns
module anreg_ability_regs_test
	import anreg_pkg::*;
();
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, anRestart = 0, go = 0, pready, pslverr, vld, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, r;
	logic [15:0] w = '0, wd, adv;
	int num_errors = 0, num_checks = 0, n, expAdv, sent = 32'h01E1;
	int pages[$];
	logic ce = 1'b1;
	always #25 clk = ~clk;
	anreg_ability_regs anreg_ability_regs_inst (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .anRestart, .partnerPageValid(vld), .partnerPageWord(wd),
		.advertWord(adv));
	anreg_partner anreg_partner_inst (.clk, .go, .w, .vld, .wd);
	task results;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task xf(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 9 && pready !== 1'b1; n++)
			@(posedge clk);
		if (n == 9)
		begin
			$display("CHECK FAILED %0t no ready from the slave", $time);
			num_errors++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xf
	initial
	begin
		void'($urandom(32'h8DBB));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		xf(0, ADDR_ADV, 0);
		chk(rd, ADV_RESET);
		chk(adv, sent);
		pages.push_back(PARTNER_RESET);
		xf(0, ADDR_PARTNER, 0);
		chk(rd, pages[$]);
		xf(0, 12'hFFC, 0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		repeat (4)
		begin
			r = $urandom;
			xf(1, ADDR_ADV, r);
			expAdv = r & 32'h1E0 | 32'h1;
			xf(0, ADDR_ADV, 0);
			chk(rd, expAdv);
			chk(adv, sent);
			anRestart <= 1'b1;
			@(posedge clk);
			anRestart <= 1'b0;
			@(posedge clk);
			sent = expAdv;
			chk(adv, sent);
			pages.push_back(r[31:16]);
			go <= 1'b1;
			w <= r[31:16];
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			xf(1, ADDR_PARTNER, ~r);
			xf(0, ADDR_PARTNER, 0);
			chk(rd, pages[$]);
		end
		// clock enable low: neither a restart nor a page may land
		xf(1, ADDR_ADV, 32'h0);
		ce <= 1'b0;
		anRestart <= 1'b1;
		go <= 1'b1;
		w <= 16'h1234;
		@(posedge clk);
		anRestart <= 1'b0;
		go <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		chk(adv, sent);
		xf(0, ADDR_PARTNER, 0);
		chk(rd, pages[$]);
		anRestart <= 1'b1;
		@(posedge clk);
		anRestart <= 1'b0;
		@(posedge clk);
		sent = 32'h1;
		chk(adv, sent);
		// reset in mid-run brings both registers back
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		sent = ADV_RESET;
		pages.push_back(PARTNER_RESET);
		chk(adv, sent);
		xf(0, ADDR_ADV, 0);
		chk(rd, sent);
		xf(0, ADDR_PARTNER, 0);
		chk(rd, pages[$]);
		results();
	end
endmodule : anreg_ability_regs_test
